// File: tpw_params.svh
// Register offsets, field positions and reset values of the PWM block.
`ifndef TPW_PARAMS_SVH
`define TPW_PARAMS_SVH
`define TPW_OFS_HALF_PERIOD 8'h00
`define TPW_OFS_DEAD_TIME 8'h04
`define TPW_OFS_SYNC_WIDTH 8'h08
`define TPW_OFS_DUTY_A 8'h0C
`define TPW_OFS_DUTY_B 8'h10
`define TPW_OFS_DUTY_C 8'h14
`define TPW_OFS_OUT_EN 8'h18
`define TPW_OFS_CHOP 8'h1C
`define TPW_OFS_CONTROL 8'h20
`define TPW_OFS_STATUS 8'h24
`define TPW_CTL_ENABLE 0
`define TPW_CTL_EXT_SYNC 1
`define TPW_CTL_DOUBLE 2
`define TPW_CTL_SYNCHRONIZE 3
`define TPW_EN_XOVER_LSB 6
`define TPW_CHOP_HIGH_EN 8
`define TPW_CHOP_LOW_EN 9
`define TPW_RST_HALF_PERIOD 16'h0100
`define TPW_RST_DEAD_TIME 10'h000
`define TPW_RST_SYNC_WIDTH 16'h0000
`define TPW_RST_DUTY 16'h0000
`define TPW_RST_OUT_EN 9'h000
`define TPW_RST_CHOP 10'h000
`define TPW_RST_CONTROL 4'h0
`define TPW_RESP_OKAY 2'b00
`define TPW_RESP_SLVERR 2'b10
`endif

// File: tpw_pkg.sv
// Types shared by the three-phase inverter PWM block.
package tpw_pkg;
  // Values latched into the timing and output control units at sync.
  typedef struct packed {
    logic [15:0] half_period;
    logic [9:0] dead_time;
    logic [2:0][15:0] duty;
    logic [8:0] out_en;
  } tpw_shadow_t;
endpackage : tpw_pkg

// File: tpw_top.sv
// Three-phase center-based PWM generator with AXI4-Lite registers.
`include "tpw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tpw_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // AXI4-Lite write channels.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Gate drive outputs.
  output logic phase_a_high_out,
  output logic phase_a_low_out,
  output logic phase_b_high_out,
  output logic phase_b_low_out,
  output logic phase_c_high_out,
  output logic phase_c_low_out,
  // Sync pin and trip pin.
  input wire logic period_sync_pulse_pin,
  output logic period_sync_pulse_drv,
  output logic period_sync_pulse_oe,
  input wire logic trip_shutdown_pin_n,
  // Interrupt pulses.
  output logic sync_irq,
  output logic trip_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic [15:0] half_period_reg_r;
  logic [9:0] dead_time_reg_r;
  logic [15:0] sync_width_reg_r;
  logic [2:0][15:0] duty_r;
  logic [8:0] output_enable_reg_r;
  logic [9:0] chop_config_reg_r;
  logic [3:0] pwm_control_reg_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_got_r;
  logic w_got_r;
  logic [31:0] wmerge;
  logic [31:0] rd_nxt;
  logic rd_hit;
  logic wr_hit;
  logic do_write;
  logic half_r;
  logic trip_q;
  tpw_pkg::tpw_shadow_t shd_r;

  // Merges the held write data into an old value under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  // Address and data are each taken once and held until the response.
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

  // Captures the write address and data channels in either order.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Decodes the write address; an unmapped one writes nothing.
  always_comb begin
    wr_hit = 1'b1;
    wmerge = 32'h0000_0000;
    unique case (aw_addr_r[7:0])
      `TPW_OFS_HALF_PERIOD: wmerge = {16'h0000, half_period_reg_r};
      `TPW_OFS_DEAD_TIME: wmerge = {22'h00_0000, dead_time_reg_r};
      `TPW_OFS_SYNC_WIDTH: wmerge = {16'h0000, sync_width_reg_r};
      `TPW_OFS_DUTY_A: wmerge = {16'h0000, duty_r[0]};
      `TPW_OFS_DUTY_B: wmerge = {16'h0000, duty_r[1]};
      `TPW_OFS_DUTY_C: wmerge = {16'h0000, duty_r[2]};
      `TPW_OFS_OUT_EN: wmerge = {23'h00_0000, output_enable_reg_r};
      `TPW_OFS_CHOP: wmerge = {22'h00_0000, chop_config_reg_r};
      `TPW_OFS_CONTROL: wmerge = {28'h000_0000, pwm_control_reg_r};
      `TPW_OFS_STATUS: wr_hit = 1'b0;
      default: wr_hit = 1'b0;
    endcase
    if (aw_addr_r[31:8] != 24'h00_0000) begin
      wr_hit = 1'b0;
    end
    wmerge = merge(wmerge, w_data_r, w_strb_r);
  end

  // Holds the software registers; keeps all sixteen half-period bits.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      half_period_reg_r <= `TPW_RST_HALF_PERIOD;
      dead_time_reg_r <= `TPW_RST_DEAD_TIME;
      sync_width_reg_r <= `TPW_RST_SYNC_WIDTH;
      duty_r <= {3{`TPW_RST_DUTY}};
      output_enable_reg_r <= `TPW_RST_OUT_EN;
      chop_config_reg_r <= `TPW_RST_CHOP;
      pwm_control_reg_r <= `TPW_RST_CONTROL;
    end else if (do_write && wr_hit) begin
      unique case (aw_addr_r[7:0])
        `TPW_OFS_HALF_PERIOD: half_period_reg_r <= wmerge[15:0];
        `TPW_OFS_DEAD_TIME: dead_time_reg_r <= wmerge[9:0];
        `TPW_OFS_SYNC_WIDTH: sync_width_reg_r <= wmerge[15:0];
        `TPW_OFS_DUTY_A: duty_r[0] <= wmerge[15:0];
        `TPW_OFS_DUTY_B: duty_r[1] <= wmerge[15:0];
        `TPW_OFS_DUTY_C: duty_r[2] <= wmerge[15:0];
        `TPW_OFS_OUT_EN: output_enable_reg_r <= wmerge[8:0];
        `TPW_OFS_CHOP: chop_config_reg_r <= wmerge[9:0];
        `TPW_OFS_CONTROL: pwm_control_reg_r <= wmerge[3:0];
        default: ;
      endcase
    end
  end

  // Write response, one cycle after both halves are held.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPW_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; the status register shows trip level and half.
  always_comb begin
    rd_hit = (s_axi_araddr[31:8] == 24'h00_0000);
    rd_nxt = 32'h0000_0000;
    unique case (s_axi_araddr[7:0])
      `TPW_OFS_HALF_PERIOD: rd_nxt = {16'h0000, half_period_reg_r};
      `TPW_OFS_DEAD_TIME: rd_nxt = {22'h00_0000, dead_time_reg_r};
      `TPW_OFS_SYNC_WIDTH: rd_nxt = {16'h0000, sync_width_reg_r};
      `TPW_OFS_DUTY_A: rd_nxt = {16'h0000, duty_r[0]};
      `TPW_OFS_DUTY_B: rd_nxt = {16'h0000, duty_r[1]};
      `TPW_OFS_DUTY_C: rd_nxt = {16'h0000, duty_r[2]};
      `TPW_OFS_OUT_EN: rd_nxt = {23'h00_0000, output_enable_reg_r};
      `TPW_OFS_CHOP: rd_nxt = {22'h00_0000, chop_config_reg_r};
      `TPW_OFS_CONTROL: rd_nxt = {28'h000_0000, pwm_control_reg_r};
      `TPW_OFS_STATUS: rd_nxt = {30'h0000_0000, trip_q, half_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read response, one cycle after the address is taken.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TPW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_nxt : 32'h0000_0000;
      s_axi_rresp <= rd_hit ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and shutdown controller.

  logic trip_m_r;
  logic trip_q_r;
  logic trip_d_r;
  logic [3:0] ext_sh_r;
  logic ext_d_r;
  logic ext_lvl;
  logic ext_rise;
  logic ext_mode;
  logic run;

  // Three flops on the trip pin; the second stage feeds the timing logic, the third finds its fall.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trip_m_r <= 1'b1;
      trip_q_r <= 1'b1;
      trip_d_r <= 1'b1;
    end else begin
      trip_m_r <= trip_shutdown_pin_n;
      trip_q_r <= trip_m_r;
      trip_d_r <= trip_q_r;
    end
  end
  assign trip_q = trip_q_r;

  // The optional extra stages add latency to the external sync edge.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_sh_r <= 4'h0;
      ext_d_r <= 1'b0;
    end else begin
      ext_sh_r <= {ext_sh_r[2:0], period_sync_pulse_pin};
      ext_d_r <= ext_lvl;
    end
  end
  assign ext_lvl = pwm_control_reg_r[`TPW_CTL_SYNCHRONIZE] ?
                   ext_sh_r[3] : ext_sh_r[1];
  assign ext_rise = ext_lvl && !ext_d_r;
  assign ext_mode = pwm_control_reg_r[`TPW_CTL_EXT_SYNC];
  // A trip holds the timing unit in reset.
  assign run = pwm_control_reg_r[`TPW_CTL_ENABLE] && trip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Three-phase timing unit.

  logic [15:0] cnt_r;
  logic [15:0] tpos;
  logic wrap;
  logic dbl;
  logic sync_evt;
  logic [15:0] sw_cnt_r;
  logic sync_pls_r;

  assign dbl = pwm_control_reg_r[`TPW_CTL_DOUBLE];
  assign wrap = cnt_r >= (shd_r.half_period - 16'h0001);
  // Start of period, internal or external, plus midpoint when double.
  assign sync_evt = run && ((wrap && half_r && !ext_mode) ||
                    (wrap && !half_r && dbl) ||
                    (ext_mode && ext_rise));
  // Distance from the period edge: up in first half, down in second.
  assign tpos = half_r ? (shd_r.half_period - 16'h0001 - cnt_r) : cnt_r;

  // Counter of core clocks and the half-period flag.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 16'h0000;
      half_r <= 1'b0;
    end else if (!run || (ext_mode && ext_rise)) begin
      cnt_r <= 16'h0000;
      half_r <= 1'b0;
    end else if (wrap) begin
      cnt_r <= 16'h0000;
      half_r <= !half_r;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Half period, dead time, duty and enables move into the units only at sync, or while stopped.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shd_r <= '0;
    end else if (!run || sync_evt) begin
      shd_r.half_period <= half_period_reg_r;
      shd_r.dead_time <= dead_time_reg_r;
      shd_r.duty <= duty_r;
      shd_r.out_en <= output_enable_reg_r;
    end
  end

  // Sync pulse lasts sync width plus one cycles and raises an interrupt.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sw_cnt_r <= 16'h0000;
      sync_pls_r <= 1'b0;
      sync_irq <= 1'b0;
      trip_irq <= 1'b0;
    end else begin
      sync_irq <= sync_evt;
      trip_irq <= trip_d_r && !trip_q_r;
      if (sync_evt) begin
        sw_cnt_r <= sync_width_reg_r;
        sync_pls_r <= 1'b1;
      end else if (sw_cnt_r != 16'h0000) begin
        sw_cnt_r <= sw_cnt_r - 16'h0001;
      end else begin
        sync_pls_r <= 1'b0;
      end
    end
  end
  assign period_sync_pulse_drv = sync_pls_r;
  assign period_sync_pulse_oe = !ext_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive chopping, output control and trip override.

  logic [7:0] chop_cnt_r;
  logic chop_r;
  logic [5:0] out_r;
  logic [5:0] pin_lvl;
  logic [2:0] raw_h;
  logic [2:0] raw_l;

  // Chopping square wave, half period of chop value plus one clocks.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chop_cnt_r <= 8'h00;
      chop_r <= 1'b0;
    end else if (chop_cnt_r >= chop_config_reg_r[7:0]) begin
      chop_cnt_r <= 8'h00;
      chop_r <= !chop_r;
    end else begin
      chop_cnt_r <= chop_cnt_r + 8'h01;
    end
  end

  // One comparator pair, crossover, chop and enable per phase.
  for (genvar i = 0; i < 3; i++) begin : g_phase
    logic signed [17:0] thr_h;
    logic signed [17:0] thr_l;
    logic signed [17:0] tpos_s;
    logic sel_h;
    logic sel_l;
    assign tpos_s = $signed({2'b00, tpos});
    // Both edges move by the dead time away from the duty instant.
    assign thr_h = $signed({3'b000, shd_r.half_period[15:1]}) -
                   $signed({{2{shd_r.duty[i][15]}}, shd_r.duty[i]}) +
                   $signed({8'h00, shd_r.dead_time});
    assign thr_l = $signed({3'b000, shd_r.half_period[15:1]}) -
                   $signed({{2{shd_r.duty[i][15]}}, shd_r.duty[i]}) -
                   $signed({8'h00, shd_r.dead_time});
    assign raw_h[i] = run && (tpos_s >= thr_h);
    assign raw_l[i] = run && (tpos_s < thr_l);
    assign sel_h = shd_r.out_en[`TPW_EN_XOVER_LSB + i] ?
                   raw_l[i] : raw_h[i];
    assign sel_l = shd_r.out_en[`TPW_EN_XOVER_LSB + i] ?
                   raw_h[i] : raw_l[i];
    // Registered high-active drive for the pair.
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        out_r[2*i] <= 1'b0;
        out_r[2*i+1] <= 1'b0;
      end else begin
        out_r[2*i] <= shd_r.out_en[2*i] && sel_h &&
          (!chop_config_reg_r[`TPW_CHOP_HIGH_EN] || chop_r);
        out_r[2*i+1] <= shd_r.out_en[2*i+1] && sel_l &&
          (!chop_config_reg_r[`TPW_CHOP_LOW_EN] || chop_r);
      end
    end
    // The trip pin forces both pins high without passing any flop.
    assign pin_lvl[2*i] = trip_shutdown_pin_n ? out_r[2*i] : 1'b1;
    assign pin_lvl[2*i+1] = trip_shutdown_pin_n ? out_r[2*i+1] : 1'b1;
  end

  // Pairs onto the six pins, high side first.
  assign phase_a_high_out = pin_lvl[0];
  assign phase_a_low_out = pin_lvl[1];
  assign phase_b_high_out = pin_lvl[2];
  assign phase_b_low_out = pin_lvl[3];
  assign phase_c_high_out = pin_lvl[4];
  assign phase_c_low_out = pin_lvl[5];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  trip_off_a: assert property (!trip_shutdown_pin_n |-> (&pin_lvl))
    else $error("Trip did not force outputs high.");
  trip_rst_a: assert property (!trip_q |=>
    cnt_r == 16'h0000 && !half_r)
    else $error("Trip did not reset the timing unit.");
  trip_irq_a: assert property ($fell(trip_q_r) |=> trip_irq)
    else $error("Trip interrupt missing.");
  half_flag_a: assert property (run && wrap && !half_r &&
    !(ext_mode && ext_rise) |=> half_r)
    else $error("Half flag not set at midpoint.");
  single_hold_a: assert property (run && !dbl && !ext_mode &&
    wrap && !half_r |=> $stable(shd_r))
    else $error("Single mode latched at midpoint.");
  double_sync_a: assert property (run && dbl && wrap && !half_r |=>
    sync_irq)
    else $error("Double mode midpoint sync missing.");
  latch_a: assert property (sync_evt |=> shd_r.duty == $past(duty_r))
    else $error("Duty not latched at sync.");
  // A width of three gives four high cycles; a later sync may extend it.
  sync_width_a: assert property (sync_evt &&
    sync_width_reg_r == 16'h0003 |=> sync_pls_r [*4] ##1
    (!sync_pls_r || $past(sync_evt) || $past(sync_evt, 2) ||
    $past(sync_evt, 3) || $past(sync_evt, 4)))
    else $error("Sync pulse width wrong.");
  count_a: assert property (run && !wrap |=> cnt_r != 16'h0000 ||
    !run || (ext_mode && $past(ext_rise)))
    else $error("Counter did not advance.");
  dead_a: assert property (!(raw_h[0] && raw_l[0]))
    else $error("Pair commanded on together.");
  oe_a: assert property (!ext_mode && sync_evt && !do_write |=>
    period_sync_pulse_oe && period_sync_pulse_drv)
    else $error("Sync pin not driven in internal mode.");

  mid_sync_c: cover property (run && dbl && wrap && !half_r);
  trip_c: cover property ($fell(trip_q_r));
  ext_sync_c: cover property (ext_mode && ext_rise && run);
  xover_c: cover property (run && shd_r.out_en[6] && out_r[0]);

endmodule : tpw_top
`default_nettype wire

// File: tpw_far_side.sv
// Far side model: external sync source and trip switch.
`timescale 1ns/1ps
`default_nettype none
module tpw_far_side (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset_n,
  // Requests from the bench.
  input wire logic [3:0] sync_len,
  input wire logic sync_go,
  input wire logic trip_low,
  // Pins toward the block.
  output logic ext_sync,
  output logic trip_n
);
  logic [3:0] left_r;
  // Holds each sync pulse for sync_len clocks, more than two.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      left_r <= 4'h0;
    end else if (sync_go) begin
      left_r <= sync_len;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
  // The source drives low between pulses; trip follows the bench.
  assign ext_sync = (left_r != 4'h0);
  assign trip_n = !trip_low;
endmodule : tpw_far_side
`default_nettype wire

// File: three_phase_inverter_pwm_tb.sv
// Self-checking bench for the three-phase PWM block.
`include "tpw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module three_phase_inverter_pwm_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sync_irq, trip_irq, period_sync_pulse_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic phase_a_high_out, phase_a_low_out, phase_b_high_out;
  logic phase_b_low_out, phase_c_high_out, phase_c_low_out;
  logic period_sync_pulse_drv, period_sync_pulse_oe, trip_shutdown_pin_n;
  logic ext_sync, sync_go = 1'b0, trip_low = 1'b0;
  logic [3:0] sync_len = 4'h4;
  logic [5:0] outs;
  int bad_count = 0, checks_done = 0;
  int h, l, ov, rh, rl, oth;
  //////////////////////////////////////////////////////////////////////////
  // Clock, pin resolution and instances.
  always #50 clk_sys = !clk_sys;
  assign period_sync_pulse_pin = period_sync_pulse_oe ?
    period_sync_pulse_drv : ext_sync;
  assign outs = {phase_a_high_out, phase_a_low_out, phase_b_high_out,
    phase_b_low_out, phase_c_high_out, phase_c_low_out};
  tpw_top i_dut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phase_a_high_out,
    .phase_a_low_out, .phase_b_high_out, .phase_b_low_out,
    .phase_c_high_out, .phase_c_low_out, .period_sync_pulse_pin,
    .period_sync_pulse_drv, .period_sync_pulse_oe, .trip_shutdown_pin_n,
    .sync_irq, .trip_irq);
  tpw_far_side i_far (.clk_sys, .reset_n, .sync_len, .sync_go, .trip_low,
    .ext_sync, .trip_n(trip_shutdown_pin_n));
  //////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d.", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // Counts a wait that ran out and closes the run.
  task automatic timed_out();
    bad_count++;
    $display("Error wait expected done seen timeout");
    end_of_test();
  endtask : timed_out
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  // One AXI4-Lite write; each channel is released when it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
        return;
      end
    end
    timed_out();
  endtask : wr
  // One AXI4-Lite read returning data and response.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        return;
      end
    end
    timed_out();
  endtask : rd
  // Waits for a rising sync edge; n is the cycles waited.
  task automatic wait_sync(output int n);
    logic p;
    p = period_sync_pulse_drv;
    for (n = 1; n < 300; n++) begin
      @(posedge clk_sys);
      if (period_sync_pulse_drv && !p) return;
      p = period_sync_pulse_drv;
    end
    timed_out();
  endtask : wait_sync
  // Counts phase a activity over one settled 40-cycle period.
  task automatic observe();
    int n;
    logic ph, pl;
    wait_sync(n);
    wait_sync(n);
    {h, l, ov, rh, rl, oth} = '0;
    ph = phase_a_high_out;
    pl = phase_a_low_out;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      h += phase_a_high_out;
      l += phase_a_low_out;
      ov += phase_a_high_out & phase_a_low_out;
      rh += phase_a_high_out & !ph;
      rl += phase_a_low_out & !pl;
      oth += |outs[3:0];
      ph = phase_a_high_out;
      pl = phase_a_low_out;
    end
  endtask : observe
  //////////////////////////////////////////////////////////////////////////
  // Reset values, field widths and refused accesses.
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(`TPW_OFS_HALF_PERIOD, d, r);
    chk("half period reset", 32'h0000_0100, d);
    rd(`TPW_OFS_CONTROL, d, r);
    chk("control reset", 32'h0000_0000, d);
    wr(`TPW_OFS_HALF_PERIOD, 32'hFFFF_FFFF, 2'b00);
    rd(`TPW_OFS_HALF_PERIOD, d, r);
    chk("half period max", 32'h0000_FFFF, d);
    wr(`TPW_OFS_DEAD_TIME, 32'hFFFF_FFFF, 2'b00);
    rd(`TPW_OFS_DEAD_TIME, d, r);
    chk("dead time width", 32'h0000_03FF, d);
    wr(`TPW_OFS_STATUS, 32'h0000_0001, 2'b10);
    rd(8'h28, d, r);
    chk("unmapped response", 32'h0000_0002, {30'h0, r});
  endtask : t_regs
  // Single update: period, sync width and one interrupt per period.
  task automatic t_period();
    int n, hi, irq;
    wr(`TPW_OFS_HALF_PERIOD, 32'h0000_0014, 2'b00);
    wr(`TPW_OFS_DEAD_TIME, 32'h0000_0000, 2'b00);
    wr(`TPW_OFS_SYNC_WIDTH, 32'h0000_0003, 2'b00);
    wr(`TPW_OFS_OUT_EN, 32'h0000_003F, 2'b00);
    wr(`TPW_OFS_CONTROL, 32'h0000_0001, 2'b00);
    wait_sync(n);
    wait_sync(n);
    chk("period", 40, n);
    {hi, irq} = '0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      hi += period_sync_pulse_drv;
      irq += sync_irq;
    end
    chk("sync width", 4, hi);
    chk("sync irq", 1, irq);
  endtask : t_period
  // Double update: midpoint sync and the half flag.
  task automatic t_double();
    int n;
    logic [31:0] s1, s2;
    logic [1:0] r;
    wr(`TPW_OFS_CONTROL, 32'h0000_0005, 2'b00);
    wait_sync(n);
    wait_sync(n);
    wait_sync(n);
    chk("double gap", 20, n);
    rd(`TPW_OFS_STATUS, s1, r);
    wait_sync(n);
    rd(`TPW_OFS_STATUS, s2, r);
    chk("half flag", 1, s1[0] ^ s2[0]);
    chk("trip level high", 1, s2[1]);
    wr(`TPW_OFS_CONTROL, 32'h0000_0001, 2'b00);
  endtask : t_double
  // Pairs, crossover, enables, dead time and chopping on phase a.
  task automatic t_outputs();
    int h1, l1;
    wr(`TPW_OFS_DUTY_A, 32'h0000_0004, 2'b00);
    observe();
    chk("pair overlap", 0, ov);
    chk("pair complement", 40, h + l);
    chk("high longer", 1, h > l);
    h1 = h;
    l1 = l;
    wr(`TPW_OFS_OUT_EN, 32'h0000_007F, 2'b00);
    observe();
    chk("crossed high", l1, h);
    chk("crossed low", h1, l);
    wr(`TPW_OFS_OUT_EN, 32'h0000_0001, 2'b00);
    observe();
    chk("lone enable", h1, h);
    chk("others off", 0, l + oth);
    wr(`TPW_OFS_OUT_EN, 32'h0000_003F, 2'b00);
    wr(`TPW_OFS_DEAD_TIME, 32'h0000_0002, 2'b00);
    observe();
    chk("dead cycles", 8, 40 - h - l);
    wr(`TPW_OFS_DEAD_TIME, 32'h0000_0000, 2'b00);
    wr(`TPW_OFS_CHOP, 32'h0000_0100, 2'b00);
    observe();
    chk("high chopped", 1, rh > 1);
    chk("low unchopped", 1, rl);
    wr(`TPW_OFS_CHOP, 32'h0000_0200, 2'b00);
    observe();
    chk("low chopped", 1, rl > 1);
    chk("high unchopped", 1, rh);
    wr(`TPW_OFS_CHOP, 32'h0000_0000, 2'b00);
  endtask : t_outputs
  // Trip forces all outputs high at once and raises its interrupt.
  task automatic t_trip();
    int n, irq;
    logic [31:0] d;
    logic [1:0] r;
    trip_low <= 1'b1;
    @(posedge clk_sys);
    #10;
    chk("trip outputs", 32'h0000_003F, {26'h0, outs});
    irq = 0;
    for (n = 0; n < 8; n++) begin
      @(posedge clk_sys);
      irq += trip_irq;
    end
    chk("trip irq", 1, irq);
    rd(`TPW_OFS_STATUS, d, r);
    chk("trip level low", 0, d[1]);
    trip_low <= 1'b0;
  endtask : t_trip
  // Idles, then sends one external pulse; n is cycles to the interrupt.
  task automatic ext_lat(output int n, output int q);
    int k;
    q = 0;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      q += sync_irq;
    end
    sync_go <= 1'b1;
    @(posedge clk_sys);
    sync_go <= 1'b0;
    for (n = 1; n < 20; n++) begin
      @(posedge clk_sys);
      if (sync_irq) return;
    end
    timed_out();
  endtask : ext_lat
  // External sync, plain and through the extra synchroniser.
  task automatic t_ext();
    int a, b, q;
    wr(`TPW_OFS_CONTROL, 32'h0000_0003, 2'b00);
    chk("sync pin released", 0, period_sync_pulse_oe);
    ext_lat(a, q);
    // Lets the pulse tail leave the deep stages before the depth changes.
    repeat (8) @(posedge clk_sys);
    wr(`TPW_OFS_CONTROL, 32'h0000_000B, 2'b00);
    ext_lat(b, q);
    chk("no internal sync", 0, q);
    chk("added latency", 2, b - a);
  endtask : t_ext
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for eight cycles, then every scenario.
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_period();
    t_double();
    t_outputs();
    t_trip();
    t_ext();
    end_of_test();
  end
endmodule : three_phase_inverter_pwm_tb
`default_nettype wire
